//--- include/hpsc_pkg.sv
// Constants and types shared by the host port strap configuration block
package hpsc_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS         = 100;
   localparam int unsigned STRAP_SAMPLE_DELAY_NS = 1500;
   // Least time, so round up to whole cycles
   localparam int unsigned STRAP_SAMPLE_CYCLES   =
      (STRAP_SAMPLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STRAP_CNT_W           = $clog2(STRAP_SAMPLE_CYCLES + 1);

   // ****************************************************************
   // Strap layout and levels
   // ****************************************************************
   localparam int unsigned STRAP_COUNT      = 3;
   localparam int unsigned STRAP_CMD_PORT   = 0;
   localparam int unsigned STRAP_SPI_MODE   = 1;
   localparam int unsigned STRAP_INTEGRITY  = 2;
   localparam logic [STRAP_COUNT-1:0] STRAP_RESET_VAL = 3'h0;
   localparam logic        CMD_PORT_I2C      = 1'h1;
   localparam logic        SPI_MODE_1_2      = 1'h1;
   localparam logic        INTEGRITY_CHKSUM  = 1'h1;

   // ****************************************************************
   // Integrity
   // ****************************************************************
   localparam int unsigned INTEG_W     = 8;
   localparam logic [7:0]  CRC8_POLY   = 8'h07;
   localparam logic [7:0]  INTEG_INIT  = 8'h00;

   // ****************************************************************
   // Strap sampler states
   // ****************************************************************
   typedef enum logic [1:0]
   {
      HPSC_ST_RESET = 2'b00,
      HPSC_ST_WAIT  = 2'b01,
      HPSC_ST_DONE  = 2'b10
   } hpsc_strap_state_t;

endpackage

//--- include/hpsc_cfg_if.sv
// Interface carrying the captured host configuration between modules
`timescale 1ns/1ps
interface hpsc_cfg_if;
   logic cfg_valid;
   logic cmd_is_i2c;
   logic spi_mode_1_2;
   logic cmd_checksum;
   logic init_start;

   modport src
   (
      output cfg_valid,
      output cmd_is_i2c,
      output spi_mode_1_2,
      output cmd_checksum,
      output init_start
   );

   modport dst
   (
      input cfg_valid,
      input cmd_is_i2c,
      input spi_mode_1_2,
      input cmd_checksum,
      input init_start
   );
endinterface

//--- verilog/hpsc_strap_sampler.sv
// Strap pin sampler: tristate in reset, delayed capture, debug drive after
`timescale 1ns/1ps
module hpsc_strap_sampler
(
   // Clock and reset
   input  wire logic                             i_sys_clk,
   input  wire logic                             i_srst,
   input  wire logic                             i_power_on_reset_n,
   // Strap pins
   input  wire logic [hpsc_pkg::STRAP_COUNT-1:0] i_strap,
   output logic      [hpsc_pkg::STRAP_COUNT-1:0] o_strap,
   output logic      [hpsc_pkg::STRAP_COUNT-1:0] o_strap_oe,
   // Debug drive request
   input  wire logic                             i_dbg_drive_en,
   input  wire logic [hpsc_pkg::STRAP_COUNT-1:0] i_dbg_drive_val,
   // Captured configuration
   hpsc_cfg_if.src                               cfg
);

   hpsc_pkg::hpsc_strap_state_t         state_r;
   logic [hpsc_pkg::STRAP_CNT_W-1:0]    cnt_r;
   logic [hpsc_pkg::STRAP_COUNT-1:0]    strap_r;
   logic                                in_reset;

   assign in_reset = i_srst || !i_power_on_reset_n;

   // ****************************************************************
   // Sequence
   // ****************************************************************
   always_ff @(posedge i_sys_clk)
   begin
      if (in_reset)
         state_r <= hpsc_pkg::HPSC_ST_RESET;
      else
      begin
         unique case (state_r)
            hpsc_pkg::HPSC_ST_RESET: state_r <= hpsc_pkg::HPSC_ST_WAIT;
            hpsc_pkg::HPSC_ST_WAIT:
               if (cnt_r == hpsc_pkg::STRAP_CNT_W'(hpsc_pkg::STRAP_SAMPLE_CYCLES - 1))
                  state_r <= hpsc_pkg::HPSC_ST_DONE;
            hpsc_pkg::HPSC_ST_DONE:  state_r <= hpsc_pkg::HPSC_ST_DONE;
            default:                 state_r <= hpsc_pkg::HPSC_ST_RESET;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (in_reset || state_r != hpsc_pkg::HPSC_ST_WAIT)
         cnt_r <= '0;
      else
         cnt_r <= cnt_r + 1'b1;
   end

   // ****************************************************************
   // Capture, held until the next power-on reset or synchronous reset
   // ****************************************************************
   always_ff @(posedge i_sys_clk)
   begin
      if (in_reset)
      begin
         strap_r       <= hpsc_pkg::STRAP_RESET_VAL;
         cfg.cfg_valid <= 1'b0;
      end
      else if (state_r == hpsc_pkg::HPSC_ST_WAIT &&
               cnt_r == hpsc_pkg::STRAP_CNT_W'(hpsc_pkg::STRAP_SAMPLE_CYCLES - 1))
      begin
         strap_r       <= i_strap;
         cfg.cfg_valid <= 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (in_reset)
         cfg.init_start <= 1'b0;
      else
         cfg.init_start <= (state_r == hpsc_pkg::HPSC_ST_RESET);
   end

   assign cfg.cmd_is_i2c   = strap_r[hpsc_pkg::STRAP_CMD_PORT];
   assign cfg.spi_mode_1_2 = strap_r[hpsc_pkg::STRAP_SPI_MODE];
   assign cfg.cmd_checksum = strap_r[hpsc_pkg::STRAP_INTEGRITY];

   // ****************************************************************
   // Pin drive
   // ****************************************************************
   // Drive only once the sample is in, so debug never corrupts a strap
   always_ff @(posedge i_sys_clk)
   begin
      if (in_reset)
      begin
         o_strap_oe <= '0;
         o_strap    <= '0;
      end
      else
      begin
         o_strap_oe <= {hpsc_pkg::STRAP_COUNT{i_dbg_drive_en && cfg.cfg_valid}};
         o_strap    <= i_dbg_drive_val;
      end
   end

endmodule

//--- verilog/hpsc_integrity.sv
// Running 8-bit CRC or checksum over a byte stream
`timescale 1ns/1ps
module hpsc_integrity
#(
   parameter logic [7:0] POLY = hpsc_pkg::CRC8_POLY
)
(
   // Clock and reset
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_srst,
   // Stream
   input  wire logic                          i_clear,
   input  wire logic                          i_valid,
   input  wire logic [hpsc_pkg::INTEG_W-1:0]  i_byte,
   input  wire logic                          i_use_checksum,
   // Result
   output logic      [hpsc_pkg::INTEG_W-1:0]  o_value
);

   function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++)
         c = c[7] ? ((c << 1) ^ POLY) : (c << 1);
      return c;
   endfunction

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst || i_clear)
         o_value <= hpsc_pkg::INTEG_INIT;
      else if (i_valid)
         o_value <= i_use_checksum ? o_value + i_byte : crc8_step(o_value, i_byte);
   end

endmodule

//--- verilog/hpsc_top.sv
// Host port strap configuration and mirror park control, top level
`timescale 1ns/1ps

// What this block does
// - A low park request parks the mirror array and a high one releases it.
// - The command port strap picks SPI when 0 and I2C when 1 for commands.
// - The host port not used for commands serves as the diagnostic monitor port.
// - The SPI mode strap picks mode 0 or 3 when 0 and mode 1 or 2 when 1.
// - The SPI mode applies to the host SPI port in either role.
// - Command transfers use an 8-bit CRC when the integrity strap is 0, else a checksum.
// - The integrity strap affects only the command port; diagnostics use the flash setting.
// - Every strap pin stays undriven while power-on reset is low.
// - Each strap is sampled about 1.5 us after power-on reset rises.
// - A strap pin may be driven for debug only after its sample is taken.
// - An unstrapped pin reads 0, giving SPI commands, mode 0 or 3 and CRC.
// - Power-on reset is active low and its rise starts configuration.
module hpsc_top
(
   // Clock and reset
   input  wire logic                            i_sys_clk,
   input  wire logic                            i_srst,
   input  wire logic                            i_power_on_reset_n,

   // Park control
   input  wire logic                            i_park_request_n,
   output logic                                 o_mirror_park,

   // Strap pins
   input  wire logic                            i_command_port_strap,
   output logic                                 o_command_port_strap,
   output logic                                 o_command_port_strap_oe,
   input  wire logic                            i_spi_mode_strap,
   output logic                                 o_spi_mode_strap,
   output logic                                 o_spi_mode_strap_oe,
   input  wire logic                            i_integrity_method_strap,
   output logic                                 o_integrity_method_strap,
   output logic                                 o_integrity_method_strap_oe,

   // Debug drive of strap pins
   input  wire logic                            i_dbg_drive_en,
   input  wire logic [hpsc_pkg::STRAP_COUNT-1:0] i_dbg_drive_val,

   // Diagnostic port integrity setting from flash
   input  wire logic                            i_diag_use_checksum,

   // Host SPI port receive side
   input  wire logic                            i_spi_frame_start,
   input  wire logic                            i_spi_byte_valid,
   input  wire logic [hpsc_pkg::INTEG_W-1:0]    i_spi_byte,

   // Host I2C port receive side
   input  wire logic                            i_i2c_frame_start,
   input  wire logic                            i_i2c_byte_valid,
   input  wire logic [hpsc_pkg::INTEG_W-1:0]    i_i2c_byte,

   // Configuration status
   output logic                                 o_cfg_valid,
   output logic                                 o_init_start,
   output logic                                 o_cmd_is_i2c,
   output logic                                 o_spi_mode_1_2,
   output logic                                 o_cmd_checksum,
   output logic                                 o_diag_checksum,

   // Port roles
   output logic                                 o_spi_is_cmd,
   output logic                                 o_spi_is_diag,
   output logic                                 o_i2c_is_cmd,
   output logic                                 o_i2c_is_diag,

   // Command path
   output logic                                 o_cmd_frame_start,
   output logic                                 o_cmd_byte_valid,
   output logic      [hpsc_pkg::INTEG_W-1:0]    o_cmd_byte,
   output logic      [hpsc_pkg::INTEG_W-1:0]    o_cmd_integrity,

   // Diagnostic path
   output logic                                 o_diag_frame_start,
   output logic                                 o_diag_byte_valid,
   output logic      [hpsc_pkg::INTEG_W-1:0]    o_diag_byte,
   output logic      [hpsc_pkg::INTEG_W-1:0]    o_diag_integrity
);

   hpsc_cfg_if                          cfg ();

   logic [hpsc_pkg::STRAP_COUNT-1:0]    strap_in;
   logic [hpsc_pkg::STRAP_COUNT-1:0]    strap_out;
   logic [hpsc_pkg::STRAP_COUNT-1:0]    strap_oe;

   logic                                cmd_start_nxt;
   logic                                cmd_valid_nxt;
   logic [hpsc_pkg::INTEG_W-1:0]        cmd_byte_nxt;
   logic                                diag_start_nxt;
   logic                                diag_valid_nxt;
   logic [hpsc_pkg::INTEG_W-1:0]        diag_byte_nxt;

   logic                                park_r;
   logic                                diag_checksum_r;

   // ****************************************************************
   // Strap capture
   // ****************************************************************
   assign strap_in[hpsc_pkg::STRAP_CMD_PORT]  = i_command_port_strap;
   assign strap_in[hpsc_pkg::STRAP_SPI_MODE]  = i_spi_mode_strap;
   assign strap_in[hpsc_pkg::STRAP_INTEGRITY] = i_integrity_method_strap;

   hpsc_strap_sampler u_sampler
   (
      .i_sys_clk          (i_sys_clk),
      .i_srst             (i_srst),
      .i_power_on_reset_n (i_power_on_reset_n),
      .i_strap            (strap_in),
      .o_strap            (strap_out),
      .o_strap_oe         (strap_oe),
      .i_dbg_drive_en     (i_dbg_drive_en),
      .i_dbg_drive_val    (i_dbg_drive_val),
      .cfg                (cfg.src)
   );

   assign o_command_port_strap        = strap_out[hpsc_pkg::STRAP_CMD_PORT];
   assign o_command_port_strap_oe     = strap_oe[hpsc_pkg::STRAP_CMD_PORT];
   assign o_spi_mode_strap            = strap_out[hpsc_pkg::STRAP_SPI_MODE];
   assign o_spi_mode_strap_oe         = strap_oe[hpsc_pkg::STRAP_SPI_MODE];
   assign o_integrity_method_strap    = strap_out[hpsc_pkg::STRAP_INTEGRITY];
   assign o_integrity_method_strap_oe = strap_oe[hpsc_pkg::STRAP_INTEGRITY];

   assign o_cfg_valid    = cfg.cfg_valid;
   assign o_init_start   = cfg.init_start;
   assign o_cmd_is_i2c   = cfg.cmd_is_i2c;
   assign o_cmd_checksum = cfg.cmd_checksum;
   // Applies to the SPI port in both roles, so no role gating here
   assign o_spi_mode_1_2 = cfg.spi_mode_1_2;

   // ****************************************************************
   // Park control
   // ****************************************************************
   // Parked by default: a mirror left unparked across power loss is the hazard
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst || !i_power_on_reset_n)
         park_r <= 1'b1;
      else
         park_r <= !i_park_request_n;
   end

   assign o_mirror_park = park_r;

   // ****************************************************************
   // Port roles
   // ****************************************************************
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst || !cfg.cfg_valid)
      begin
         o_spi_is_cmd  <= 1'b0;
         o_spi_is_diag <= 1'b0;
         o_i2c_is_cmd  <= 1'b0;
         o_i2c_is_diag <= 1'b0;
      end
      else
      begin
         o_spi_is_cmd  <= cfg.cmd_is_i2c != hpsc_pkg::CMD_PORT_I2C;
         o_i2c_is_cmd  <= cfg.cmd_is_i2c == hpsc_pkg::CMD_PORT_I2C;
         o_spi_is_diag <= cfg.cmd_is_i2c == hpsc_pkg::CMD_PORT_I2C;
         o_i2c_is_diag <= cfg.cmd_is_i2c != hpsc_pkg::CMD_PORT_I2C;
      end
   end

   // ****************************************************************
   // Byte routing
   // ****************************************************************
   // Traffic before capture is dropped: the roles are not yet known
   always_comb
   begin
      cmd_start_nxt  = 1'b0;
      cmd_valid_nxt  = 1'b0;
      cmd_byte_nxt   = i_spi_byte;
      diag_start_nxt = 1'b0;
      diag_valid_nxt = 1'b0;
      diag_byte_nxt  = i_i2c_byte;
      if (cfg.cfg_valid)
      begin
         if (cfg.cmd_is_i2c == hpsc_pkg::CMD_PORT_I2C)
         begin
            cmd_start_nxt  = i_i2c_frame_start;
            cmd_valid_nxt  = i_i2c_byte_valid;
            cmd_byte_nxt   = i_i2c_byte;
            diag_start_nxt = i_spi_frame_start;
            diag_valid_nxt = i_spi_byte_valid;
            diag_byte_nxt  = i_spi_byte;
         end
         else
         begin
            cmd_start_nxt  = i_spi_frame_start;
            cmd_valid_nxt  = i_spi_byte_valid;
            cmd_byte_nxt   = i_spi_byte;
            diag_start_nxt = i_i2c_frame_start;
            diag_valid_nxt = i_i2c_byte_valid;
            diag_byte_nxt  = i_i2c_byte;
         end
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         o_cmd_frame_start  <= 1'b0;
         o_cmd_byte_valid   <= 1'b0;
         o_cmd_byte         <= '0;
         o_diag_frame_start <= 1'b0;
         o_diag_byte_valid  <= 1'b0;
         o_diag_byte        <= '0;
      end
      else
      begin
         o_cmd_frame_start  <= cmd_start_nxt;
         o_cmd_byte_valid   <= cmd_valid_nxt;
         o_cmd_byte         <= cmd_byte_nxt;
         o_diag_frame_start <= diag_start_nxt;
         o_diag_byte_valid  <= diag_valid_nxt;
         o_diag_byte        <= diag_byte_nxt;
      end
   end

   // ****************************************************************
   // Integrity
   // ****************************************************************
   // Flash setting is sampled per frame so a change never splits one
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         diag_checksum_r <= 1'b0;
      else if (diag_start_nxt)
         diag_checksum_r <= i_diag_use_checksum;
   end

   assign o_diag_checksum = diag_checksum_r;

   hpsc_integrity u_cmd_integ
   (
      .i_sys_clk      (i_sys_clk),
      .i_srst         (i_srst),
      .i_clear        (o_cmd_frame_start),
      .i_valid        (o_cmd_byte_valid),
      .i_byte         (o_cmd_byte),
      .i_use_checksum (cfg.cmd_checksum == hpsc_pkg::INTEGRITY_CHKSUM),
      .o_value        (o_cmd_integrity)
   );

   hpsc_integrity u_diag_integ
   (
      .i_sys_clk      (i_sys_clk),
      .i_srst         (i_srst),
      .i_clear        (o_diag_frame_start),
      .i_valid        (o_diag_byte_valid),
      .i_byte         (o_diag_byte),
      .i_use_checksum (diag_checksum_r),
      .o_value        (o_diag_integrity)
   );

endmodule

//--- verification/hpsc_host_model.sv
// Board model: power manager park request and strap resistors
`timescale 1ns/1ps
module hpsc_host_model
(
   // Stimulus
   input  wire logic       i_supply_fail,
   input  wire logic       i_fitted,
   input  wire logic [2:0] i_level,
   // Device side of the pins
   input  wire logic [2:0] i_drv,
   input  wire logic [2:0] i_drv_oe,
   output logic            o_park_request_n,
   output logic      [2:0] o_pin
);
   // ********************
   // Pin levels
   // ********************
   // Park level as soon as the supply looks doomed
   assign o_park_request_n = !i_supply_fail;

   // Released pin takes the strap resistor level, or the weak pull-down when none is fitted, never keeps its last value
   always_comb
   begin
      for (int b = 0; b < 3; b++)
      begin
         o_pin[b] = i_drv_oe[b] ? i_drv[b] : (i_fitted ? i_level[b] : 1'b0);
      end
   end
endmodule

//--- verification/hpsc_asserts.sv
// Checker for strap capture, debug drive and park behaviour at the top ports
`timescale 1ns/1ps
module hpsc_asserts
(
   // Clock and resets
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_power_on_reset_n,
   // Inputs
   input wire logic i_park_request_n,
   input wire logic i_dbg_drive_en,
   input wire logic i_diag_use_checksum,
   input wire logic i_i2c_frame_start,
   // Outputs
   input wire logic o_mirror_park,
   input wire logic o_command_port_strap_oe,
   input wire logic o_spi_mode_strap_oe,
   input wire logic o_integrity_method_strap_oe,
   input wire logic o_cfg_valid,
   input wire logic o_init_start,
   input wire logic o_cmd_is_i2c,
   input wire logic o_spi_mode_1_2,
   input wire logic o_cmd_checksum,
   input wire logic o_diag_checksum,
   input wire logic o_spi_is_cmd,
   input wire logic o_spi_is_diag,
   input wire logic o_i2c_is_cmd,
   input wire logic o_i2c_is_diag
);
   logic [2:0] oe_w;
   logic [2:0] cfg_w;

   assign oe_w  = {o_integrity_method_strap_oe, o_spi_mode_strap_oe, o_command_port_strap_oe};
   assign cfg_w = {o_cmd_checksum, o_spi_mode_1_2, o_cmd_is_i2c};

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_srst);

   // ********************
   // Checks
   // ********************
   property p_park;
      i_power_on_reset_n |=> o_mirror_park == !$past(i_park_request_n);
   endproperty
   a_park: assert property (p_park)
      else $error("mirror park does not follow request");

   property p_tristate;
      !i_power_on_reset_n |=> oe_w == 3'h0;
   endproperty
   a_tristate: assert property (p_tristate)
      else $error("strap pin driven in reset");

   property p_drive_late;
      (|oe_w) |-> $past(o_cfg_valid) && $past(i_dbg_drive_en);
   endproperty
   a_drive_late: assert property (p_drive_late)
      else $error("strap pin driven before sample");

   // Some slack around the nominal 1.5 us figure
   property p_sample_time;
      disable iff (i_srst || !i_power_on_reset_n)
      $rose(i_power_on_reset_n) |->
         (!o_cfg_valid)[*8] ##1 (!o_cfg_valid)[*6] ##[1:3] o_cfg_valid;
   endproperty
   a_sample_time: assert property (p_sample_time)
      else $error("strap sample time wrong");

   property p_init;
      disable iff (i_srst || !i_power_on_reset_n)
      $rose(i_power_on_reset_n) |-> ##[1:2] o_init_start ##1 !o_init_start;
   endproperty
   a_init: assert property (p_init)
      else $error("no init pulse after reset rise");

   property p_hold;
      disable iff (i_srst || !i_power_on_reset_n)
      o_cfg_valid |=> o_cfg_valid && $stable(cfg_w);
   endproperty
   a_hold: assert property (p_hold)
      else $error("captured straps changed");

   property p_roles;
      disable iff (i_srst || !i_power_on_reset_n)
      o_cfg_valid |=> {o_spi_is_cmd, o_spi_is_diag, o_i2c_is_cmd, o_i2c_is_diag}
         == {!o_cmd_is_i2c, o_cmd_is_i2c, o_cmd_is_i2c, !o_cmd_is_i2c};
   endproperty
   a_roles: assert property (p_roles)
      else $error("port roles disagree with strap");

   property p_diag_sel;
      o_cfg_valid && o_i2c_is_diag && i_i2c_frame_start
         |=> o_diag_checksum == $past(i_diag_use_checksum);
   endproperty
   a_diag_sel: assert property (p_diag_sel)
      else $error("diag method not from flash setting");

   c_cfg: cover property ($rose(o_cfg_valid));
   c_drive: cover property ($rose(o_command_port_strap_oe));
   c_park: cover property ($fell(o_mirror_park));
endmodule

bind hpsc_top hpsc_asserts u_hpsc_asserts
(
   .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_power_on_reset_n(i_power_on_reset_n),
   .i_park_request_n(i_park_request_n), .i_dbg_drive_en(i_dbg_drive_en),
   .i_diag_use_checksum(i_diag_use_checksum), .i_i2c_frame_start(i_i2c_frame_start),
   .o_mirror_park(o_mirror_park), .o_command_port_strap_oe(o_command_port_strap_oe),
   .o_spi_mode_strap_oe(o_spi_mode_strap_oe), .o_cfg_valid(o_cfg_valid),
   .o_integrity_method_strap_oe(o_integrity_method_strap_oe), .o_init_start(o_init_start),
   .o_cmd_is_i2c(o_cmd_is_i2c), .o_spi_mode_1_2(o_spi_mode_1_2),
   .o_cmd_checksum(o_cmd_checksum), .o_diag_checksum(o_diag_checksum),
   .o_spi_is_cmd(o_spi_is_cmd), .o_spi_is_diag(o_spi_is_diag),
   .o_i2c_is_cmd(o_i2c_is_cmd), .o_i2c_is_diag(o_i2c_is_diag)
);

//--- verification/hpsc_top_test.sv
// Self-checking bench for the host port strap configuration block
`timescale 1ns/1ps
module hpsc_top_test;
   logic       clk = 0, srst = 1, por_n = 0, fail = 0, fit = 1, en = 0, dflash = 0;
   logic       ss = 0, sv = 0, is = 0, iv = 0;
   logic [2:0] lvl = 3'h0, dval = 3'h0, pin, drv, oe;
   logic [7:0] sb = 8'h00, ib = 8'h00, cint, dint;
   logic       park_n, mpark, cfgv, i2c, mode, csum, dcs, s_cmd, s_dg, i_cmd, i_dg;
   logic [7:0] msg [4] = '{8'h31, 8'hc2, 8'h00, 8'hff};
   logic       cbv, dbv;
   int         fail_count = 0, n_checks = 0, cyc = 0, nc = 0, nd = 0;

   hpsc_top u_hpsc_top
   (
      .i_sys_clk(clk), .i_srst(srst), .i_power_on_reset_n(por_n),
      .i_park_request_n(park_n), .o_mirror_park(mpark),
      .i_command_port_strap(pin[0]), .o_command_port_strap(drv[0]),
      .o_command_port_strap_oe(oe[0]), .i_spi_mode_strap(pin[1]),
      .o_spi_mode_strap(drv[1]), .o_spi_mode_strap_oe(oe[1]),
      .i_integrity_method_strap(pin[2]), .o_integrity_method_strap(drv[2]),
      .o_integrity_method_strap_oe(oe[2]), .i_dbg_drive_en(en),
      .i_dbg_drive_val(dval), .i_diag_use_checksum(dflash),
      .i_spi_frame_start(ss), .i_spi_byte_valid(sv), .i_spi_byte(sb),
      .i_i2c_frame_start(is), .i_i2c_byte_valid(iv), .i_i2c_byte(ib),
      .o_cfg_valid(cfgv), .o_init_start(), .o_cmd_is_i2c(i2c), .o_spi_mode_1_2(mode),
      .o_cmd_checksum(csum), .o_diag_checksum(dcs), .o_spi_is_cmd(s_cmd),
      .o_spi_is_diag(s_dg), .o_i2c_is_cmd(i_cmd), .o_i2c_is_diag(i_dg),
      .o_cmd_frame_start(), .o_cmd_byte_valid(cbv), .o_cmd_byte(), .o_cmd_integrity(cint),
      .o_diag_frame_start(), .o_diag_byte_valid(dbv), .o_diag_byte(), .o_diag_integrity(dint)
   );

   hpsc_host_model u_hpsc_host_model
   (
      .i_supply_fail(fail), .i_fitted(fit), .i_level(lvl), .i_drv(drv), .i_drv_oe(oe),
      .o_park_request_n(park_n), .o_pin(pin)
   );

   initial
   begin
      forever #50 clk = ~clk;
   end

   // Routed byte pulses per port, read where they are settled
   always @(negedge clk)
   begin
      nc += cbv;
      nd += dbv;
   end

   // ********************
   // Helpers
   // ********************
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // CRC-8 (0x07, init 0) or plain sum over the test frame
   function automatic logic [7:0] ref_int(input logic sum);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 4; i++)
      begin
         if (sum)
            c = c + msg[i];
         else
         begin
            c = c ^ msg[i];
            for (int k = 0; k < 8; k++)
               c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
         end
      end
      return c;
   endfunction

   task automatic send(input logic on_i2c);
      @(posedge clk);
      is <= on_i2c;
      ss <= !on_i2c;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         is <= 1'b0;
         ss <= 1'b0;
         iv <= on_i2c;
         sv <= !on_i2c;
         ib <= msg[i];
         sb <= msg[i];
      end
      @(posedge clk);
      iv <= 1'b0;
      sv <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ********************
   // Scenarios
   // ********************
   // Debug drive is requested all through the wait, so an early drive shows up
   task automatic t_config(input logic [2:0] v, input logic fitted);
      int n;
      logic [2:0] e;
      n = 0;
      e = fitted ? v : 3'h0;
      @(posedge clk);
      por_n <= 1'b0;
      lvl <= v;
      fit <= fitted;
      en <= 1'b1;
      dval <= v;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("oe in reset", oe, 3'h0);
      @(posedge clk);
      por_n <= 1'b1;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (cfgv !== 1'b1 && n < 40);
      check("sample delay", n >= 15 && n <= 18, 1'b1);
      check("oe at sample", oe, 3'h0);
      check("straps", {csum, mode, i2c}, e);
      @(negedge clk);
      check("roles", {s_cmd, s_dg, i_cmd, i_dg}, {!e[0], e[0], e[0], !e[0]});
      check("debug drive", {oe, pin}, {3'h7, v});
      @(posedge clk);
      lvl <= ~v;
      en <= 1'b0;
      repeat (3) @(negedge clk);
      check("strap hold", {csum, mode, i2c}, e);
      check("oe off", oe, 3'h0);
   endtask

   task automatic t_integrity(input logic [2:0] e, input logic flash);
      @(posedge clk);
      dflash <= flash;
      nc = 0;
      nd = 0;
      send(e[0]);
      check("cmd integrity", cint, ref_int(e[2]));
      check("cmd bytes", {nc[3:0], nd[3:0]}, 8'h40);
      send(!e[0]);
      check("diag bytes", {nc[3:0], nd[3:0]}, 8'h44);
      check("diag method", dcs, flash);
      check("diag integrity", dint, ref_int(flash));
   endtask

   task automatic t_park;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         fail <= !i[0];
         @(posedge clk);
         @(negedge clk);
         check("mirror park", mpark, !i[0]);
      end
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         end_sim;
      end
   end

   initial
   begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      for (int v = 0; v < 8; v++)
      begin
         t_config(v[2:0], 1'b1);
         t_integrity(v[2:0], v[1]);
      end
      t_config(3'h7, 1'b0);
      t_park;
      end_sim;
   end
endmodule
